// ===== core/smcb_pkg.sv
// Shared constants and types of the supply monitor and CAN bias control.
package smcb_pkg;
  // Register indices; byte address is four times the index.
  localparam logic [7:0] IDX_MODE = 8'h01;
  localparam logic [7:0] IDX_SUPCTL = 8'h10;
  localparam logic [7:0] IDX_SUPSTAT = 8'h1B;
  localparam logic [7:0] IDX_CANCTL = 8'h20;
  localparam logic [7:0] IDX_EVSTAT = 8'h61;
  localparam logic [7:0] IDX_EVMASK = 8'h62;
  localparam logic [7:0] IDX_EVEN = 8'h64;
  // Field positions.
  localparam int THR_LSB = 0;
  localparam int AUX_LSB = 2;
  localparam int SSS_LSB = 1;
  localparam int EV_PO = 0;
  localparam int EV_SW = 1;
  // Reset values.
  localparam logic [1:0] CMC_RST = 2'h0;
  localparam logic [1:0] EV_MASK_RST = 2'h0;
  localparam logic [1:0] EV_EN_RST = 2'h3;
  // Times in microseconds and the clock rate in MHz.
  localparam int CLK_MHZ = 125;
  localparam int T_STARTUP_US = 1000;
  localparam int T_SILENCE_US = 1000;
  localparam int T_RESET_US = 1000;
  localparam int STARTUP_CYC = T_STARTUP_US * CLK_MHZ;
  localparam int SILENCE_CYC = T_SILENCE_US * CLK_MHZ;
  localparam int RESET_CYC = T_RESET_US * CLK_MHZ;
  localparam int FILT_LEN = 4;
  // Host mode request codes.
  localparam logic [2:0] REQ_STANDBY = 3'h4;
  localparam logic [2:0] REQ_SLEEP = 3'h1;
  localparam logic [2:0] REQ_NORMAL = 3'h7;
  // Comparator input positions.
  localparam int NCMP = 10;
  localparam int C_PON = 0, C_POFF = 1, C_B2V = 2, C_UV90 = 3, C_UV80 = 4;
  localparam int C_UV70 = 5, C_UV60 = 6, C_SUV = 7, C_SOV = 8, C_OT = 9;
  typedef enum logic [2:0] {
    SMCB_OFF, SMCB_RESET, SMCB_STANDBY, SMCB_NORMAL, SMCB_SLEEP, SMCB_OVERT
  } smcb_mode_t;
  typedef enum logic [2:0] {
    SMCB_T_OFF, SMCB_T_OFFLINE, SMCB_T_BIAS, SMCB_T_ACTIVE, SMCB_T_LISTEN
  } smcb_trx_t;
endpackage

// ===== core/smcb_top.sv
// Supply monitor, auxiliary output and CAN bias control with APB registers.
`timescale 1ns/10ps
`default_nettype none
// Function
// R1 - Low battery enters off; MCU supply until 2V.
// R2 - Start-up delay, then reset mode, flag power-on.
// R3 - MCU supply under selected threshold forces reset.
// R4 - Threshold field: 90, 80, 70, 60 percent.
// R5 - Threshold field loads from start-up bits.
// R6 - Supply warning event below 90 percent, when enabled.
// R7 - Supply status bit shows below 90 percent.
// R8 - Aux config field switches output per mode.
// R9 - Aux config field loads from start-up bit.
// R10 - Sensor status: ok, under, over, disabled.
// R11 - Variants without sensor supply read 00.
// R12 - Overtemperature keeps inhibit output level unchanged.
// R13 - Overtemperature disables sensor supply output.
// R14 - Active or listen-only biases bus 2.5V.
// R15 - Offline biases 2.5V, ground after silence.
// R16 - In Normal, transceiver follows CAN mode field.
// R17 - Standby, Sleep force offline or offline bias.
// R18 - CAN field: 01 active unless below 90 percent, 10 active, 11 listen, 00 offline.
// R19 - Comparators synchronised and filtered before use.
module smcb_top #(
  parameter int unsigned STARTUP_CYC = smcb_pkg::STARTUP_CYC,
  parameter int unsigned SILENCE_CYC = smcb_pkg::SILENCE_CYC,
  parameter int unsigned RESET_CYC = smcb_pkg::RESET_CYC,
  parameter bit HAS_SENSOR = 1'b1
) (
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // APB slave.
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [3:0]  pstrb_i,
  output logic             pready_o,
  output logic [31:0]      prdata_o,
  output logic             pslverr_o,
  // Non-volatile start-up settings.
  input  wire logic [1:0]  startup_threshold_bits_i,
  input  wire logic        aux_startup_bit_i,
  // Analog comparators, indexed as in the package.
  input  wire logic [smcb_pkg::NCMP-1:0] cmp_i,
  input  wire logic        bus_rx_i,
  // Supply, transceiver and interrupt outputs.
  output logic             mcu_supply_output_o,
  output logic             battery_inhibit_output_o,
  output logic             sensor_supply_output_o,
  output logic             sys_reset_o,
  output smcb_pkg::smcb_mode_t chip_mode_o,
  output smcb_pkg::smcb_trx_t  trx_mode_o,
  output logic             bias_2v5_o,
  output logic             irq_o
);
  import smcb_pkg::*;

  if (STARTUP_CYC >= 2**24 || SILENCE_CYC >= 2**24 || RESET_CYC >= 2**24
      || STARTUP_CYC == 0 || SILENCE_CYC == 0 || RESET_CYC == 0) begin : g_chk
    $error("smcb_top: counts must lie in 1 .. 2**24-1");
  end

  // Aux output state for a mode and a config field.
  function automatic logic aux_on(logic [1:0] cfg, smcb_mode_t m);
    unique case (cfg)
      2'h0: aux_on = 1'b0;
      2'h1: aux_on = (m == SMCB_NORMAL);
      2'h2: aux_on = (m inside {SMCB_NORMAL, SMCB_STANDBY, SMCB_RESET});
      default: aux_on = (m inside {SMCB_NORMAL, SMCB_STANDBY, SMCB_RESET,
                                   SMCB_SLEEP});
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Reset release through two flip-flops.
  logic [1:0] rst_sync_q;
  logic       rst_n;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  //////////////////////////////////////////////////////////////////////////
  // Comparators pass two flops, then must agree for FILT_LEN samples.
  // The filter trades a few cycles of latency for immunity to glitches.
  logic [NCMP:0] s1_q, s2_q, flt_q;
  logic [FILT_LEN-1:0] hist_q [NCMP+1];
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      // The bus bit resets to its idle level, so no false edge follows.
      s1_q <= {1'b1, {NCMP{1'b0}}};
      s2_q <= {1'b1, {NCMP{1'b0}}};
      flt_q <= {1'b1, {NCMP{1'b0}}};
      for (int i = 0; i < NCMP; i++) begin
        hist_q[i] <= '0;
      end
      hist_q[NCMP] <= '1;
    end else begin
      s1_q <= {bus_rx_i, cmp_i};
      s2_q <= s1_q;
      for (int i = 0; i <= NCMP; i++) begin
        hist_q[i] <= {hist_q[i][FILT_LEN-2:0], s2_q[i]}; // [R19]
        if (&hist_q[i]) begin
          flt_q[i] <= 1'b1;
        end else if (~|hist_q[i]) begin
          flt_q[i] <= 1'b0;
        end
      end
    end
  end

  logic uv90, uv_sel, ot, bus_q;
  logic [1:0] thr_q;
  // Threshold field picks one of four comparators.
  always_comb begin
    unique case (thr_q)
      2'h0: uv_sel = flt_q[C_UV90]; // [R4]
      2'h1: uv_sel = flt_q[C_UV80];
      2'h2: uv_sel = flt_q[C_UV70];
      default: uv_sel = flt_q[C_UV60];
    endcase
  end
  assign uv90 = flt_q[C_UV90];
  assign ot = flt_q[C_OT];

  //////////////////////////////////////////////////////////////////////////
  // APB decode; zero wait states, unmapped index answers with pslverr.
  logic       acc, wr, setup, hit;
  logic [7:0] idx;
  logic [1:0] aux_q, cmc_q, ev_q, mask_q, en_q;
  logic [2:0] req_q;
  assign idx = paddr_i[9:2];
  assign hit = (paddr_i[11:10] == 2'h0) && (paddr_i[1:0] == 2'h0)
               && (idx inside {IDX_MODE, IDX_SUPCTL, IDX_SUPSTAT,
                               IDX_CANCTL, IDX_EVSTAT, IDX_EVMASK, IDX_EVEN});
  assign setup = psel_i && !penable_i;
  assign acc = psel_i && penable_i;
  assign wr = acc && pwrite_i && hit && pstrb_i[0];
  assign pready_o = 1'b1;

  smcb_mode_t mode_q, mode_d;
  smcb_trx_t  trx_q;
  logic [1:0] sss;
  // Read data is prepared in the setup cycle, so it leaves a flop.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      prdata_o <= 32'h0;
      pslverr_o <= 1'b0;
    end else if (setup) begin
      pslverr_o <= !hit;
      prdata_o <= 32'h0;
      if (!pwrite_i && hit) begin
        unique case (idx)
          IDX_MODE: prdata_o[6:0] <= {1'b0, 3'(mode_q), req_q};
          IDX_SUPCTL: prdata_o[3:0] <= {aux_q, thr_q};
          IDX_SUPSTAT: prdata_o[2:0] <= {sss, uv90}; // [R7]
          IDX_CANCTL: prdata_o[1:0] <= cmc_q;
          IDX_EVSTAT: prdata_o[1:0] <= ev_q;
          IDX_EVMASK: prdata_o[1:0] <= mask_q;
          default: prdata_o[1:0] <= en_q;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Control registers. Start-up fields reload on reset and on leaving off.
  logic leave_off;
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      thr_q <= 2'h0;
      aux_q <= 2'h0;
      cmc_q <= CMC_RST;
      mask_q <= EV_MASK_RST;
      en_q <= EV_EN_RST;
      req_q <= REQ_STANDBY;
    end else if (leave_off) begin
      thr_q <= startup_threshold_bits_i; // [R5]
      aux_q <= {2{aux_startup_bit_i}}; // [R9]
    end else if (wr) begin
      unique case (idx)
        IDX_SUPCTL: begin
          thr_q <= pwdata_i[THR_LSB+:2];
          aux_q <= pwdata_i[AUX_LSB+:2];
        end
        IDX_CANCTL: cmc_q <= pwdata_i[1:0];
        IDX_EVMASK: mask_q <= pwdata_i[1:0];
        IDX_EVEN: en_q <= pwdata_i[1:0];
        IDX_MODE: req_q <= pwdata_i[2:0];
        default: ;
      endcase
    end
  end

  // First cycle after reset release also counts as a power-up load.
  logic boot_q;
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      boot_q <= 1'b1;
    end else begin
      boot_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Chip mode machine with its single delay counter.
  logic [23:0] cnt_q;
  logic        cnt_clr;
  assign leave_off = boot_q || (mode_q == SMCB_OFF && mode_d == SMCB_RESET);
  always_comb begin
    mode_d = mode_q;
    cnt_clr = 1'b0;
    unique case (mode_q)
      SMCB_OFF: begin
        if (!flt_q[C_PON]) begin
          cnt_clr = 1'b1;
        end else if (cnt_q == 24'(STARTUP_CYC - 1)) begin
          mode_d = SMCB_RESET; // [R2]
        end
      end
      SMCB_RESET: begin
        if (cnt_q == 24'(RESET_CYC - 1) && !uv_sel) begin
          mode_d = SMCB_STANDBY;
        end
      end
      SMCB_STANDBY, SMCB_NORMAL: begin
        if (uv_sel) begin
          mode_d = SMCB_RESET; // [R3]
        end else if (req_q == REQ_NORMAL) begin
          mode_d = SMCB_NORMAL;
        end else if (req_q == REQ_SLEEP) begin
          mode_d = SMCB_SLEEP;
        end else begin
          mode_d = SMCB_STANDBY;
        end
      end
      SMCB_SLEEP: begin
        if (req_q != REQ_SLEEP) begin
          mode_d = SMCB_RESET;
        end
      end
      SMCB_OVERT: begin
        if (!ot) begin
          mode_d = SMCB_RESET;
        end
      end
    endcase
    if (mode_q inside {SMCB_RESET, SMCB_STANDBY, SMCB_NORMAL} && ot) begin
      mode_d = SMCB_OVERT;
    end
    if (flt_q[C_POFF]) begin
      mode_d = SMCB_OFF; // [R1]
    end
    if (mode_d != mode_q) begin
      cnt_clr = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= SMCB_OFF;
      cnt_q <= 24'h0;
    end else begin
      mode_q <= mode_d;
      cnt_q <= cnt_clr ? 24'h0 : ((cnt_q == 24'hFFFFFF) ? cnt_q : cnt_q + 24'h1);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Events: set wins over a write-one clear in the same cycle.
  logic uv90_d_q;
  logic [1:0] ev_set;
  assign ev_set[EV_PO] = mode_q == SMCB_OFF && mode_d == SMCB_RESET; // [R2]
  assign ev_set[EV_SW] = uv90 && !uv90_d_q && en_q[EV_SW]; // [R6]
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ev_q <= 2'h0;
      uv90_d_q <= 1'b0;
    end else begin
      uv90_d_q <= uv90;
      ev_q <= (ev_q & ~((wr && idx == IDX_EVSTAT) ? pwdata_i[1:0] : 2'h0))
              | ev_set;
    end
  end
  assign irq_o = |(ev_q & mask_q);

  //////////////////////////////////////////////////////////////////////////
  // Supply and auxiliary outputs.
  logic ot_hold;
  assign ot_hold = (mode_d == SMCB_OVERT);
  assign sss = !HAS_SENSOR ? 2'h0 : // [R11]
               !sensor_supply_output_o ? 2'h3 : // [R10]
               flt_q[C_SUV] ? 2'h1 : flt_q[C_SOV] ? 2'h2 : 2'h0;
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      mcu_supply_output_o <= 1'b0;
      battery_inhibit_output_o <= 1'b0;
      sensor_supply_output_o <= 1'b0;
      sys_reset_o <= 1'b1;
    end else begin
      // In off the supply holds on until battery is under 2 V.
      mcu_supply_output_o <= (mode_d == SMCB_OFF) ? flt_q[C_B2V] // [R1]
                           : !(mode_d inside {SMCB_SLEEP, SMCB_OVERT});
      if (!ot_hold) begin
        battery_inhibit_output_o <= !HAS_SENSOR && aux_on(aux_q, mode_d); // [R8]
      end // In overtemperature the inhibit level is frozen. [R12]
      sensor_supply_output_o <= HAS_SENSOR && !ot_hold // [R13]
                                && aux_on(aux_q, mode_d); // [R8]
      sys_reset_o <= mode_d inside {SMCB_OFF, SMCB_RESET, SMCB_OVERT};
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Bus silence timer: any receive edge restarts it.
  logic [23:0] sil_q;
  logic        silent;
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      bus_q <= 1'b1;
      sil_q <= 24'h0;
    end else begin
      bus_q <= flt_q[NCMP];
      if (bus_q != flt_q[NCMP]) begin
        sil_q <= 24'h0;
      end else if (!silent) begin
        sil_q <= sil_q + 24'h1;
      end
    end
  end
  assign silent = (sil_q >= 24'(SILENCE_CYC));

  // Transceiver mode from chip mode, CAN field and bus activity.
  smcb_trx_t trx_d, offl;
  assign offl = silent ? SMCB_T_OFFLINE : SMCB_T_BIAS; // [R15]
  always_comb begin
    trx_d = offl; // [R17]
    if (mode_d inside {SMCB_OFF, SMCB_OVERT}) begin
      trx_d = SMCB_T_OFF;
    end else if (mode_d == SMCB_NORMAL) begin
      unique case (cmc_q) // [R16]
        2'h1: trx_d = uv90 ? offl : SMCB_T_ACTIVE; // [R18]
        2'h2: trx_d = SMCB_T_ACTIVE;
        2'h3: trx_d = SMCB_T_LISTEN;
        default: trx_d = offl;
      endcase
    end
  end
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      trx_q <= SMCB_T_OFF;
      bias_2v5_o <= 1'b0;
    end else begin
      trx_q <= trx_d;
      bias_2v5_o <= trx_d inside {SMCB_T_ACTIVE, SMCB_T_LISTEN, // [R14]
                                  SMCB_T_BIAS}; // [R15]
    end
  end
  assign trx_mode_o = trx_q;
  assign chip_mode_o = mode_q;

  //////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  property p_poff;
    flt_q[C_POFF] |=> mode_q == SMCB_OFF ##0 mcu_supply_output_o == $past(flt_q[C_B2V]);
  endproperty
  a_poff: assert property (p_poff) else $error("power-off entry wrong"); // [R1]

  sequence s_leave_off;
    mode_q == SMCB_OFF ##1 mode_q == SMCB_RESET;
  endsequence
  property p_po;
    s_leave_off |-> ev_q[EV_PO] && thr_q == $past(startup_threshold_bits_i);
  endproperty
  a_po: assert property (p_po) else $error("power-on flag or load missing"); // [R2]

  property p_uvrst;
    mode_q inside {SMCB_STANDBY, SMCB_NORMAL} && uv_sel && !flt_q[C_POFF]
      && !ot
      |=> mode_q == SMCB_RESET ##1 sys_reset_o;
  endproperty
  a_uvrst: assert property (p_uvrst) else $error("undervoltage reset missed"); // [R3]

  property p_thr;
    thr_q == 2'h3 |-> uv_sel == flt_q[C_UV60];
  endproperty
  a_thr: assert property (p_thr) else $error("threshold decode wrong"); // [R4]

  property p_warn;
    uv90 && !uv90_d_q && en_q[EV_SW] |=> ev_q[EV_SW] ##1 ev_q[EV_SW] || $past(wr);
  endproperty
  a_warn: assert property (p_warn) else $error("supply warning not captured"); // [R6]

  property p_stat;
    setup && !pwrite_i && idx == IDX_SUPSTAT |=> prdata_o[0] == $past(uv90);
  endproperty
  a_stat: assert property (p_stat) else $error("supply status bit wrong"); // [R7]

  property p_ot;
    mode_q == SMCB_OVERT ##1 mode_q == SMCB_OVERT
      |-> !sensor_supply_output_o && $stable(battery_inhibit_output_o);
  endproperty
  a_ot: assert property (p_ot) else $error("overtemperature output wrong"); // [R12]

  property p_sss;
    !sensor_supply_output_o |-> sss == (HAS_SENSOR ? 2'h3 : 2'h0);
  endproperty
  a_sss: assert property (p_sss) else $error("sensor status wrong"); // [R10]

  property p_bias;
    trx_q inside {SMCB_T_ACTIVE, SMCB_T_LISTEN} |-> bias_2v5_o;
  endproperty
  a_bias: assert property (p_bias) else $error("bus not biased"); // [R14]

  property p_silence;
    silent && bus_q == flt_q[NCMP] && mode_d == SMCB_STANDBY
      |=> trx_q == SMCB_T_OFFLINE && !bias_2v5_o;
  endproperty
  a_silence: assert property (p_silence) else $error("silent bus biased"); // [R15]

  property p_listen;
    mode_d == SMCB_NORMAL && cmc_q == 2'h3 |=> trx_q == SMCB_T_LISTEN;
  endproperty
  a_listen: assert property (p_listen) else $error("CAN mode not followed"); // [R16]
endmodule
`default_nettype wire

// ===== verif/smcb_front_model.sv
// Model of the battery, supply comparators and CAN bus seen by the block.
`timescale 1ns/10ps
`default_nettype none
module smcb_front_model (
  // Clock and stimulus levels.
  input  wire logic       clk_i,
  input  wire logic [1:0] bat_lvl_i,
  input  wire logic [6:0] mcu_pct_i,
  input  wire logic [1:0] sens_i,
  input  wire logic       hot_i,
  input  wire logic       bus_act_i,
  // Comparator and bus receive levels.
  output logic [9:0]      cmp_o,
  output logic            bus_rx_o
);
  logic [2:0] tick_q = 3'h0;
  // Battery 2 is above power-on, 1 between 2 V and power-off, 0 below 2 V.
  assign cmp_o = {hot_i, sens_i[1], sens_i[0], mcu_pct_i < 7'h3C,
                  mcu_pct_i < 7'h46, mcu_pct_i < 7'h50, mcu_pct_i < 7'h5A,
                  bat_lvl_i != 2'h0, bat_lvl_i != 2'h2, bat_lvl_i == 2'h2};
  // Edges come eight cycles apart so the input filter keeps them.
  always @(posedge clk_i) begin
    tick_q <= tick_q + 3'h1;
    if (!bus_act_i) begin
      bus_rx_o <= 1'b1;
    end else if (tick_q == 3'h7) begin
      bus_rx_o <= ~bus_rx_o;
    end
  end
endmodule
`default_nettype wire

// ===== verif/supply_monitor_can_bias_control_test.sv
// Self-checking bench of the supply monitor and CAN bias control.
`timescale 1ns/10ps
`default_nettype none
module supply_monitor_can_bias_control_test;
  import smcb_pkg::*;
  // Short counts keep the run brief; expectations use the same values.
  localparam int unsigned ST = 20;
  localparam int unsigned SIL = 40;
  localparam int unsigned RS = 30;
  // Bench-driven inputs.
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0;
  logic [3:0]  pstrb_i = 4'hF;
  logic [1:0]  startup_threshold_bits_i = 2'h2;
  logic        aux_startup_bit_i = 1'b1;
  logic [1:0]  bat_q = 2'h0;
  logic [1:0]  sens_q = 2'h0;
  logic [6:0]  pct_q = 7'h64;
  logic        hot_q = 1'b0;
  logic        act_q = 1'b0;
  // Observed outputs and bench state.
  logic [9:0]  cmp_i;
  logic        bus_rx_i, pready_o, pslverr_o, mcu_supply_output_o, inh_o;
  logic        sensor_supply_output_o, sys_reset_o, bias_2v5_o, irq_o;
  logic [31:0] prdata_o, prdata_inh, rd_inh;
  logic        err_q;
  smcb_mode_t  chip_mode_o;
  smcb_trx_t   trx_mode_o;
  int          n_fail = 0;
  int          samples_checked = 0;
  // Free-running 125 MHz clock.
  always #4 clk_i = ~clk_i;
  // Sensor variant under test.
  smcb_top #(.STARTUP_CYC(ST), .SILENCE_CYC(SIL), .RESET_CYC(RS)) dut (
    .clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .pstrb_i, .pready_o, .prdata_o, .pslverr_o, .startup_threshold_bits_i,
    .aux_startup_bit_i, .cmp_i, .bus_rx_i, .mcu_supply_output_o,
    .battery_inhibit_output_o(), .sensor_supply_output_o, .sys_reset_o,
    .chip_mode_o, .trx_mode_o, .bias_2v5_o, .irq_o);
  // Inhibit variant on the same inputs, watched for its pin and status.
  smcb_top #(.STARTUP_CYC(ST), .SILENCE_CYC(SIL), .RESET_CYC(RS),
    .HAS_SENSOR(1'b0)) dut_inh (
    .clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .pstrb_i, .pready_o(), .prdata_o(prdata_inh), .pslverr_o(),
    .startup_threshold_bits_i, .aux_startup_bit_i, .cmp_i, .bus_rx_i,
    .mcu_supply_output_o(), .battery_inhibit_output_o(inh_o),
    .sensor_supply_output_o(), .sys_reset_o(), .chip_mode_o(),
    .trx_mode_o(), .bias_2v5_o(), .irq_o());
  // Battery, supply comparators and bus.
  smcb_front_model env (.clk_i, .bat_lvl_i(bat_q), .mcu_pct_i(pct_q),
    .sens_i(sens_q), .hot_i(hot_q), .bus_act_i(act_q), .cmp_o(cmp_i),
    .bus_rx_o(bus_rx_i));
  ////////////////////////////////////////////////////////////////////////////
  // Compare one value and count it.
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Print the counts and the verdict, then stop.
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // One APB transfer; the request holds until pready is seen high.
  task automatic apb(input logic wr, input logic [7:0] idx,
                     input logic [31:0] wd, output logic [31:0] rd);
    int i;
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= {2'h0, idx, 2'h0};
    pwdata_i <= wd;
    @(posedge clk_i);
    penable_i <= 1'b1;
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (pready_o !== 1'b1 && i < 16);
    rd = prdata_o;
    rd_inh = prdata_inh;
    err_q = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    if (pready_o !== 1'b1) begin
      chk("pready", 32'h1, 32'h0);
      final_report();
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
    logic [31:0] d;
    apb(1'b1, idx, wd, d);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Wait a bounded time for a chip mode; a timeout ends the run.
  task automatic wait_mode(input smcb_mode_t m, output int n);
    for (n = 0; n < 600 && chip_mode_o !== m; n++) begin
      @(posedge clk_i);
    end
    chk("chip mode", 32'(m), 32'(chip_mode_o));
    if (chip_mode_o !== m) final_report();
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Power-up: start-up delay, power-on flag, start-up fields, bad address.
  task automatic t_power_up;
    logic [31:0] d;
    int n;
    bat_q <= 2'h2;
    wait_mode(SMCB_RESET, n);
    chk("startup wait", 32'h1, 32'(n >= ST));
    apb(1'b0, IDX_EVSTAT, 32'h0, d);
    chk("power-on flag", 32'h1, d);
    apb(1'b0, IDX_SUPCTL, 32'h0, d);
    chk("start fields", 32'hE, d);
    wait_mode(SMCB_STANDBY, n);
    chk("reset released", 32'h0, 32'(sys_reset_o));
    apb(1'b0, 8'h05, 32'h0, d);
    chk("unmapped error", 32'h1, 32'(err_q));
    chk("unmapped data", 32'h0, d);
    wr(IDX_EVSTAT, 32'h1);
  endtask
  // Each threshold code: just above keeps running, just below resets.
  task automatic t_thresholds;
    logic [6:0] lvl [4] = '{7'h5A, 7'h50, 7'h46, 7'h3C};
    int n;
    for (int k = 0; k < 4; k++) begin
      wr(IDX_SUPCTL, {28'h0, 2'h2, 2'(k)});
      pct_q <= lvl[k] + 7'h3;
      settle(16);
      chk("above level", 32'h0, 32'(sys_reset_o));
      pct_q <= lvl[k] - 7'h3;
      settle(16);
      chk("below level", 32'h1, 32'(sys_reset_o));
      pct_q <= 7'h64;
      wait_mode(SMCB_STANDBY, n);
    end
  endtask
  // Warning event, status bit and interrupt raise, mask and clear.
  task automatic t_warning;
    logic [31:0] d;
    pct_q <= 7'h55;
    settle(16);
    apb(1'b0, IDX_SUPSTAT, 32'h0, d);
    chk("supply status", 32'h1, d & 32'h1);
    apb(1'b0, IDX_EVSTAT, 32'h0, d);
    chk("warning event", 32'h2, d);
    chk("irq masked", 32'h0, 32'(irq_o));
    wr(IDX_EVMASK, 32'h2);
    settle(2);
    chk("irq raised", 32'h1, 32'(irq_o));
    pct_q <= 7'h64;
    settle(16);
    apb(1'b0, IDX_SUPSTAT, 32'h0, d);
    chk("supply status", 32'h0, d & 32'h1);
    wr(IDX_EVSTAT, 32'h2);
    settle(2);
    chk("irq cleared", 32'h0, 32'(irq_o));
    wr(IDX_EVEN, 32'h0);
    pct_q <= 7'h55;
    settle(16);
    apb(1'b0, IDX_EVSTAT, 32'h0, d);
    chk("warning off", 32'h0, d);
    pct_q <= 7'h64;
    settle(16);
    wr(IDX_EVEN, 32'h3);
  endtask
  // Auxiliary output per mode, sensor status codes and overtemperature.
  task automatic t_aux;
    logic [31:0] d;
    logic [1:0] st [3] = '{2'h1, 2'h2, 2'h0};
    int n;
    for (int k = 0; k < 4; k++) begin
      wr(IDX_SUPCTL, {28'h0, 2'(k), 2'h3});
      settle(4);
      chk("aux standby", 32'(k >= 2), 32'(sensor_supply_output_o));
    end
    wr(IDX_MODE, 32'(REQ_NORMAL));
    wait_mode(SMCB_NORMAL, n);
    for (int k = 3; k >= 0; k--) begin
      wr(IDX_SUPCTL, {28'h0, 2'(k), 2'h3});
      settle(4);
      chk("aux normal", 32'(k >= 1), 32'(sensor_supply_output_o));
    end
    apb(1'b0, IDX_SUPSTAT, 32'h0, d);
    chk("sensor off", 32'h6, d);
    chk("no sensor", 32'h0, rd_inh);
    wr(IDX_SUPCTL, 32'hF);
    for (int k = 0; k < 3; k++) begin
      sens_q <= st[k];
      settle(12);
      apb(1'b0, IDX_SUPSTAT, 32'h0, d);
      chk("sensor status", {29'h0, st[k], 1'b0}, d);
      chk("no sensor", 32'h0, rd_inh);
    end
    hot_q <= 1'b1;
    wait_mode(SMCB_OVERT, n);
    settle(2);
    chk("sensor hot", 32'h0, 32'(sensor_supply_output_o));
    chk("inhibit held", 32'h1, 32'(inh_o));
    hot_q <= 1'b0;
    wait_mode(SMCB_STANDBY, n);
    wr(IDX_MODE, 32'(REQ_SLEEP));
    wait_mode(SMCB_SLEEP, n);
    chk("aux sleep", 32'h1, 32'(sensor_supply_output_o));
    wr(IDX_SUPCTL, 32'hB);
    settle(4);
    chk("aux sleep", 32'h0, 32'(sensor_supply_output_o));
    wr(IDX_MODE, 32'(REQ_STANDBY));
    wait_mode(SMCB_STANDBY, n);
  endtask
  // CAN mode decode in Normal, then bias from bus activity in Standby.
  task automatic t_can;
    smcb_trx_t et [4] = '{SMCB_T_OFFLINE, SMCB_T_ACTIVE, SMCB_T_ACTIVE,
                          SMCB_T_LISTEN};
    int n;
    wr(IDX_MODE, 32'(REQ_NORMAL));
    wait_mode(SMCB_NORMAL, n);
    for (int k = 0; k < 4; k++) begin
      wr(IDX_CANCTL, 32'(k));
      settle(4);
      chk("trx mode", 32'(et[k]), 32'(trx_mode_o));
      chk("bias", 32'(k != 0), 32'(bias_2v5_o));
    end
    wr(IDX_CANCTL, 32'h1);
    wr(IDX_MODE, 32'(REQ_STANDBY));
    wait_mode(SMCB_STANDBY, n);
    settle(4);
    chk("trx standby", 32'(SMCB_T_OFFLINE), 32'(trx_mode_o));
    act_q <= 1'b1;
    settle(32);
    chk("trx busy", 32'(SMCB_T_BIAS), 32'(trx_mode_o));
    chk("bias busy", 32'h1, 32'(bias_2v5_o));
    act_q <= 1'b0;
    settle(SIL / 2);
    chk("bias held", 32'h1, 32'(bias_2v5_o));
    settle(SIL + 16);
    chk("bias dropped", 32'h0, 32'(bias_2v5_o));
  endtask
  // Battery loss: off mode with the supply kept until below 2 V.
  task automatic t_power_off;
    int n;
    bat_q <= 2'h1;
    wait_mode(SMCB_OFF, n);
    settle(2);
    chk("supply kept", 32'h1, 32'(mcu_supply_output_o));
    bat_q <= 2'h0;
    settle(16);
    chk("supply dropped", 32'h0, 32'(mcu_supply_output_o));
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Reset for two cycles, then run every scenario.
  initial begin
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    settle(4);
    t_power_up();
    t_thresholds();
    t_warning();
    t_aux();
    t_can();
    t_power_off();
    final_report();
  end
endmodule
`default_nettype wire
